// ===== include/wake_pkg.sv
// Package with constants and types of the wake input monitor
// Operation
// - Three wake inputs, each with own pull, filter mode and wake enable.
// - Rising and falling threshold crossings both produce an event.
// - Event raises interrupt in normal or stop, wakes in sleep or fail-safe.
// - Per input: static sensing always active, or cyclic sensing in timer window.
// - Filter starts on crossing; event only if level holds the whole interval.
// - Filter code 00 is static 16 us, 01 is static 64 us.
// - Code 10 cyclic on first timer, 11 on second timer, both 16 us.
// - Per-input wake enable bit; disabled inputs never wake the device.
// - Per-input wake source bit records which input woke the device.
// - Level status shows pin level in normal and stop, enabled or not.
// - In cyclic sensing level status holds the level of the last sample.
// - Alternate output pins as wake inputs: fixed 16 us, own status bits.
// - Pull code 00 off (reset default), 01 pull-down, 10 pull-up.
// - Pull code 11 switches pull-up on high level, pull-down on low level.
package wake_pkg;

  // ----------------------------------------------------------------------
  // Device operating modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_FAILSAFE
  } op_mode_e;

  // ----------------------------------------------------------------------
  // Sizes and field codes
  // ----------------------------------------------------------------------
  localparam int WAKE_NUM = 3;
  localparam int ALT_NUM = 2;
  localparam logic [1:0] PULL_OFF = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;
  localparam logic [1:0] PULL_AUTO = 2'h3;
  localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
  localparam logic [1:0] FLT_STATIC_LONG = 2'h1;
  localparam logic [1:0] FLT_CYCLIC_T1 = 2'h2;
  localparam logic [1:0] FLT_CYCLIC_T2 = 2'h3;

  // ----------------------------------------------------------------------
  // Timing: filter times in ns, counts rounded up at 25 MHz
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int FILT_SHORT_NS = 16000;
  localparam int FILT_LONG_NS = 64000;
  localparam int FILT_CNT_W = 11;
  localparam logic [FILT_CNT_W-1:0] FILT_SHORT_CYC = FILT_CNT_W'(
    (FILT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [FILT_CNT_W-1:0] FILT_LONG_CYC = FILT_CNT_W'(
    (FILT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// ===== rtl/wake_edge_filter.sv
// Edge filter for one wake input: validates threshold crossings
`timescale 1ns/1ps
module wake_edge_filter #(
  parameter int CNT_W = wake_pkg::FILT_CNT_W
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic active_i,
  input wire logic level_i,
  input wire logic [CNT_W-1:0] limit_i,
  output logic event_o,
  output logic stable_o
);
  import wake_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [2:0] primed_q;

  // ----------------------------------------------------------------------
  // Filter counter and validated level
  // ----------------------------------------------------------------------
  // First three active cycles only adopt the pin level: the synchroniser
  // still shows its reset zeros for two of them, and a pin strapped high
  // at reset must not fake an event.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
      stable_o <= 1'b0;
      primed_q <= '0;
      event_o <= 1'b0;
    end else begin
      event_o <= 1'b0;
      if (!active_i) begin
        cnt_q <= '0;
      end else if (!primed_q[2]) begin
        primed_q <= {primed_q[1:0], 1'b1};
        stable_o <= level_i;
        cnt_q <= '0;
      end else if (level_i == stable_o) begin
        cnt_q <= '0;
      end else if (cnt_q == limit_i - CNT_W'(1)) begin
        stable_o <= level_i;
        event_o <= 1'b1;
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property event_after_full_count_p;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      event_o |-> $past(cnt_q) == $past(limit_i) - CNT_W'(1);
  endproperty
  filter_full_count_a: assert property (event_after_full_count_p)
    else $error("event before full filter interval");

  crossing_back_restart_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (active_i && primed_q[2] && level_i == stable_o) |=> cnt_q == '0)
    else $error("filter counter not restarted on crossing back");

  stable_change_event_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      ($changed(stable_o) && $past(primed_q[2])) |-> event_o)
    else $error("validated level changed without event");

endmodule

// ===== rtl/wake_input_monitor.sv
// Wake input monitor: three wake inputs and two alternate wake pins
`timescale 1ns/1ps
module wake_input_monitor #(
  parameter int CNT_W = wake_pkg::FILT_CNT_W
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire wake_pkg::op_mode_e op_mode_i,
  input wire logic [wake_pkg::WAKE_NUM-1:0] wake_input_n_i,
  input wire logic [wake_pkg::ALT_NUM-1:0] alt_output_pins_i,
  input wire logic [wake_pkg::ALT_NUM-1:0] alt_wake_cfg_i,
  input wire logic [2*wake_pkg::WAKE_NUM-1:0] pull_source_control_i,
  input wire logic [2*wake_pkg::WAKE_NUM-1:0] filter_mode_control_i,
  input wire logic [wake_pkg::WAKE_NUM-1:0] wake_enable_control_i,
  input wire logic first_cycle_timer_on_i,
  input wire logic second_cycle_timer_on_i,
  input wire logic [wake_pkg::WAKE_NUM-1:0] wake_source_clear_i,
  input wire logic [wake_pkg::ALT_NUM-1:0] alt_wake_source_clear_i,
  output logic [wake_pkg::WAKE_NUM-1:0] wake_source_status_o,
  output logic [wake_pkg::ALT_NUM-1:0] alt_wake_source_status_o,
  output logic [wake_pkg::WAKE_NUM-1:0] input_level_status_o,
  output logic [wake_pkg::WAKE_NUM-1:0] pull_up_en_o,
  output logic [wake_pkg::WAKE_NUM-1:0] pull_down_en_o,
  output logic interrupt_o,
  output logic wake_up_o
);
  import wake_pkg::*;

  localparam int PIN_NUM = WAKE_NUM + ALT_NUM;

  // Narrower counters could not reach the long filter count
  if (CNT_W < FILT_CNT_W) begin : gen_bad_width
    $error("CNT_W too narrow for the long filter count");
  end

  // ----------------------------------------------------------------------
  // Filter code decoding
  // ----------------------------------------------------------------------
  function automatic logic [CNT_W-1:0] filt_limit(input logic [1:0] code);
    if (code == FLT_STATIC_LONG) begin
      filt_limit = CNT_W'(FILT_LONG_CYC);
    end else begin
      filt_limit = CNT_W'(FILT_SHORT_CYC);
    end
  endfunction

  function automatic logic is_cyclic(input logic [1:0] code);
    is_cyclic = code[1];
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [PIN_NUM-1:0] pin_meta_q;
  logic [PIN_NUM-1:0] pin_sync_q;

  // Pins are asynchronous; only the second stage feeds the logic
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= {alt_output_pins_i, wake_input_n_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Timer window edges
  // ----------------------------------------------------------------------
  logic [1:0] timer_on_q;
  logic [1:0] timer_end;

  // Sample point is the end of each on-window
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_on_q <= '0;
    end else begin
      timer_on_q <= {second_cycle_timer_on_i, first_cycle_timer_on_i};
    end
  end
  assign timer_end = timer_on_q &
    ~{second_cycle_timer_on_i, first_cycle_timer_on_i};

  // ----------------------------------------------------------------------
  // Per-input filters
  // ----------------------------------------------------------------------
  logic [PIN_NUM-1:0] pin_active;
  logic [PIN_NUM-1:0] pin_event;
  logic [PIN_NUM-1:0] pin_stable;
  logic [WAKE_NUM-1:0] wake_sample;
  logic [1:0] flt_code [WAKE_NUM];

  // Cyclic inputs listen only inside the window of their timer
  always_comb begin
    for (int i = 0; i < WAKE_NUM; i++) begin
      flt_code[i] = filter_mode_control_i[2*i +: 2];
      if (!is_cyclic(flt_code[i])) begin
        pin_active[i] = 1'b1;
        wake_sample[i] = 1'b0;
      end else if (flt_code[i] == FLT_CYCLIC_T1) begin
        pin_active[i] = first_cycle_timer_on_i;
        wake_sample[i] = timer_end[0];
      end else begin
        pin_active[i] = second_cycle_timer_on_i;
        wake_sample[i] = timer_end[1];
      end
    end
    for (int j = 0; j < ALT_NUM; j++) begin
      pin_active[WAKE_NUM+j] = alt_wake_cfg_i[j];
    end
  end

  for (genvar g = 0; g < PIN_NUM; g++) begin : gen_filter
    logic [CNT_W-1:0] limit;
    // Alternate pins always use the short static filter
    if (g < WAKE_NUM) begin : gen_wake
      assign limit = filt_limit(filter_mode_control_i[2*g +: 2]);
    end else begin : gen_alt
      assign limit = CNT_W'(FILT_SHORT_CYC);
    end
    wake_edge_filter #(
      .CNT_W(CNT_W)
    ) u_filter (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .active_i(pin_active[g]),
      .level_i(pin_sync_q[g]),
      .limit_i(limit),
      .event_o(pin_event[g]),
      .stable_o(pin_stable[g])
    );
  end

  // ----------------------------------------------------------------------
  // Mode qualification
  // ----------------------------------------------------------------------
  logic active_mode;
  logic low_power_mode;
  logic [WAKE_NUM-1:0] wake_hit;
  logic [ALT_NUM-1:0] alt_hit;

  assign active_mode = (op_mode_i == MODE_NORMAL) ||
    (op_mode_i == MODE_STOP);
  assign low_power_mode = (op_mode_i == MODE_SLEEP) ||
    (op_mode_i == MODE_FAILSAFE);
  assign wake_hit = pin_event[WAKE_NUM-1:0] & wake_enable_control_i;
  assign alt_hit = pin_event[PIN_NUM-1:WAKE_NUM];

  // ----------------------------------------------------------------------
  // Interrupt and wake pulses
  // ----------------------------------------------------------------------
  // Interrupts are not gated by the wake enable, only wakes are
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      interrupt_o <= 1'b0;
      wake_up_o <= 1'b0;
    end else begin
      interrupt_o <= active_mode && (|pin_event);
      wake_up_o <= low_power_mode && ((|wake_hit) || (|alt_hit));
    end
  end

  // ----------------------------------------------------------------------
  // Sticky wake source status
  // ----------------------------------------------------------------------
  // A set in the clearing cycle wins, so no wake is lost
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wake_source_status_o <= '0;
      alt_wake_source_status_o <= '0;
    end else begin
      wake_source_status_o <= (wake_source_status_o &
        ~wake_source_clear_i) | (wake_hit & {WAKE_NUM{low_power_mode}});
      alt_wake_source_status_o <= (alt_wake_source_status_o &
        ~alt_wake_source_clear_i) | alt_hit;
    end
  end
  // Only low-power wakes set wake_source_status_o; alternate pin events set theirs in any mode

  // ----------------------------------------------------------------------
  // Level status
  // ----------------------------------------------------------------------
  // Frozen outside normal and stop; cyclic inputs take the last sample
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      input_level_status_o <= '0;
    end else if (active_mode) begin
      for (int i = 0; i < WAKE_NUM; i++) begin
        if (!is_cyclic(flt_code[i])) begin
          input_level_status_o[i] <= pin_sync_q[i];
        end else if (wake_sample[i]) begin
          input_level_status_o[i] <= pin_sync_q[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pull current sources
  // ----------------------------------------------------------------------
  // Automatic mode follows the validated level, so a glitch cannot flip it
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pull_up_en_o <= '0;
      pull_down_en_o <= '0;
    end else begin
      for (int i = 0; i < WAKE_NUM; i++) begin
        case (pull_source_control_i[2*i +: 2])
          PULL_DOWN: begin
            pull_up_en_o[i] <= 1'b0;
            pull_down_en_o[i] <= 1'b1;
          end
          PULL_UP: begin
            pull_up_en_o[i] <= 1'b1;
            pull_down_en_o[i] <= 1'b0;
          end
          PULL_AUTO: begin
            pull_up_en_o[i] <= pin_stable[i];
            pull_down_en_o[i] <= ~pin_stable[i];
          end
          default: begin
            pull_up_en_o[i] <= 1'b0;
            pull_down_en_o[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence event_in_active_s;
    active_mode && (|pin_event);
  endsequence

  sequence irq_pulse_s;
    ##1 interrupt_o;
  endsequence

  irq_in_active_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      event_in_active_s |-> irq_pulse_s)
    else $error("event in active mode gave no interrupt");

  wake_in_sleep_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      wake_up_o |-> $past(low_power_mode) && !$past(active_mode))
    else $error("wake pulse outside sleep or fail-safe");

  disabled_no_wake_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (pin_event[WAKE_NUM-1:0] != '0 && wake_hit == '0 && alt_hit == '0)
      |=> !wake_up_o)
    else $error("disabled input woke the device");

  source_sticky_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (wake_source_status_o[0] && !wake_source_clear_i[0])
      |=> wake_source_status_o[0])
    else $error("wake source bit lost without clear");

  source_set_wins_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (low_power_mode && wake_hit != '0)
      |=> (wake_source_status_o & $past(wake_hit)) == $past(wake_hit))
    else $error("wake source bit not set on wake");

  alt_status_set_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      alt_hit[0] |=> alt_wake_source_status_o[0])
    else $error("alternate wake event not recorded");

  pull_exclusive_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (pull_up_en_o & pull_down_en_o) == '0)
    else $error("pull-up and pull-down both on");

  auto_pull_follow_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (pull_source_control_i[1:0] == PULL_AUTO)
      |=> pull_up_en_o[0] == $past(pin_stable[0]))
    else $error("automatic pull did not follow level");

  cyclic_level_hold_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (is_cyclic(flt_code[2]) && !wake_sample[2])
      |=> $stable(input_level_status_o[2]))
    else $error("cyclic level changed between samples");

  static_level_live_a: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (active_mode && !is_cyclic(flt_code[2]))
      |=> input_level_status_o[2] == $past(pin_sync_q[2]))
    else $error("static level status not live");

endmodule

// ===== dv/wake_switch_model.sv
// Model of the switches and sensors on the wake pins
`timescale 1ns/1ps
module wake_switch_model (
  input wire logic clk_sys_i,
  input wire logic [wake_pkg::WAKE_NUM-1:0] closed_i,
  input wire logic [wake_pkg::WAKE_NUM-1:0] level_i,
  input wire logic [wake_pkg::WAKE_NUM-1:0] pull_up_en_i,
  input wire logic [wake_pkg::WAKE_NUM-1:0] pull_down_en_i,
  output logic [wake_pkg::WAKE_NUM-1:0] pin_o
);
  import wake_pkg::*;
  // ------------------------------------------------------------
  // Pin levels
  // ------------------------------------------------------------
  logic float_q = 1'b0;
  // Open pin with no source wanders, so it can never pass a filter
  always_ff @(posedge clk_sys_i) begin
    float_q <= ~float_q;
  end
  // Closed switch beats the weak current sources
  always_comb begin
    for (int i = 0; i < WAKE_NUM; i++) begin
      pin_o[i] = closed_i[i] ? level_i[i] : pull_up_en_i[i] ? 1'b1 :
        pull_down_en_i[i] ? 1'b0 : float_q;
    end
  end
endmodule

// ===== dv/wake_input_monitor_test.sv
// Testbench of the wake input monitor with queued pulse checks
`timescale 1ns/1ps
module wake_input_monitor_test;
  import wake_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  typedef struct {logic wk; int lo; int hi;} note_s;
  localparam int N16 = 400;
  localparam int N64 = 1600;
  localparam int CYC_LIMIT = 20000; // About three times the planned run
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  op_mode_e mode = MODE_NORMAL;
  logic [2:0] closed = 3'h7;
  logic [2:0] level = 3'h0;
  logic [2:0] pins;
  logic [1:0] alt = 2'h0;
  logic [1:0] alt_cfg = 2'h0;
  logic [5:0] pull = 6'h0;
  logic [5:0] filt = 6'h0;
  logic [2:0] wen = 3'h0;
  logic t1 = 1'b0;
  logic t2 = 1'b0;
  logic [2:0] clr = 3'h0;
  logic [1:0] alt_clr = 2'h0;
  logic [2:0] src, lvl, pu, pd;
  logic [1:0] alt_src;
  logic irq, wake;
  int cyc = 0;
  int bad_count = 0;
  int checks_done = 0;
  note_s exp_q[$];

  always #20 clk_sys_i = ~clk_sys_i;

  wake_switch_model wake_switch_model_i (.clk_sys_i(clk_sys_i),
    .closed_i(closed), .level_i(level), .pull_up_en_i(pu),
    .pull_down_en_i(pd), .pin_o(pins));

  wake_input_monitor wake_input_monitor_i (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .op_mode_i(mode), .wake_input_n_i(pins),
    .alt_output_pins_i(alt), .alt_wake_cfg_i(alt_cfg),
    .pull_source_control_i(pull), .filter_mode_control_i(filt),
    .wake_enable_control_i(wen), .first_cycle_timer_on_i(t1),
    .second_cycle_timer_on_i(t2), .wake_source_clear_i(clr),
    .alt_wake_source_clear_i(alt_clr), .wake_source_status_o(src),
    .alt_wake_source_status_o(alt_src), .input_level_status_o(lvl),
    .pull_up_en_o(pu), .pull_down_en_o(pd), .interrupt_o(irq),
    .wake_up_o(wake));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic check(input string what, input logic [7:0] e,
                       input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask

  // Window is loose: the timer path may skip the pin synchroniser
  task automatic expect_pulse(input logic wk, input int n);
    note_s nt;
    nt.wk = wk;
    nt.lo = cyc + n - 4;
    nt.hi = cyc + n + 6;
    exp_q.push_back(nt);
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Any pulse takes the oldest note; a pulse with no note is bad
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == CYC_LIMIT) begin
      bad_count++;
      print_verdict();
    end else if (reset_n_i && (irq === 1'b1 || wake === 1'b1)) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("BAD pulse expected none seen %b%b", irq, wake);
      end else begin
        note_s nt;
        logic in_win;
        nt = exp_q.pop_front();
        in_win = (cyc >= nt.lo) && (cyc <= nt.hi);
        check("pulse", {6'h0, ~nt.wk, nt.wk}, {6'h0, irq, wake});
        check("pulse_time", 8'h1, {7'h0, in_win});
      end
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int g;
    void'($urandom(953));
    tick(20);
    reset_n_i <= 1'b1;
    tick(3);
    check("src_rst", 8'h0, {5'h0, src});
    check("pull_rst", 8'h0, {2'h0, pu, pd});
    // Fixed pull codes on input one
    for (int c = 0; c < 3; c++) begin
      pull <= {4'h0, 2'(c)};
      tick(3);
      check("pull", {6'h0, c == 2, c == 1}, {6'h0, pu[0], pd[0]});
    end
    // One edge per mode, rising and falling in turn, wake only when enabled
    pull <= {4'h0, PULL_AUTO};
    for (int m = 0; m < 4; m++) begin
      mode <= op_mode_e'(m);
      wen <= {2'h0, m >= 2};
      tick(2);
      level[0] <= ~level[0];
      expect_pulse(m >= 2, N16 + 3);
      tick(N16 + 12);
      check("auto", {6'h0, level[0], ~level[0]},
            {6'h0, pu[0], pd[0]});
      check("src_one", {7'h0, m >= 2}, {7'h0, src[0]});
      if (m == 0) check("lvl", 8'h1, {5'h0, lvl});
    end
    // Open switch rests on the auto pull-down, no event
    closed <= 3'h6;
    tick(N16 + 12);
    check("open_pull", 8'h1, {7'h0, pd[0]});
    closed <= 3'h7;
    clr <= 3'h1;
    tick(1);
    clr <= 3'h0;
    tick(2);
    check("src_clr", 8'h0, {5'h0, src});
    // Disabled input in fail-safe gives nothing
    level[1] <= 1'b1;
    tick(N16 + 12);
    check("src_off", 8'h0, {5'h0, src});
    // Short glitch, brief return, then hold: count restarts
    mode <= MODE_NORMAL;
    g = 50 + $urandom % 300;
    tick(2);
    level[0] <= 1'b1;
    tick(g);
    level[0] <= 1'b0;
    tick(5);
    level[0] <= 1'b1;
    expect_pulse(1'b0, N16 + 3);
    tick(N16 + 12);
    // Long static filter on input two
    filt <= 6'h04;
    tick(2);
    level[1] <= 1'b0;
    expect_pulse(1'b0, N64 + 3);
    tick(N64 + 12);
    // Cyclic sensing of input three on each timer
    for (int k = 0; k < 2; k++) begin
      filt <= {k ? FLT_CYCLIC_T2 : FLT_CYCLIC_T1, 4'h4};
      tick(2);
      level[2] <= ~level[2];
      tick(N16 + 20);
      check("lvl_held", {7'h0, ~level[2]}, {7'h0, lvl[2]});
      t1 <= (k == 0);
      t2 <= (k == 1);
      expect_pulse(1'b0, N16 + 3);
      tick(N16 + 40);
      t1 <= 1'b0;
      t2 <= 1'b0;
      tick(3);
      check("lvl_smp", {7'h0, level[2]}, {7'h0, lvl[2]});
    end
    // Alternate pins: only the configured one reports
    alt_cfg <= 2'h1;
    tick(2);
    alt <= 2'h3;
    expect_pulse(1'b0, N16 + 3);
    tick(N16 + 12);
    check("alt_src", 8'h1, {6'h0, alt_src});
    alt_clr <= 2'h1;
    tick(1);
    alt_clr <= 2'h0;
    tick(2);
    check("alt_clr", 8'h0, {6'h0, alt_src});
    check("missing", 8'h0, 8'(exp_q.size()));
    print_verdict();
  end
endmodule
